/* File: rtl/ess_pkg.sv */
/*
  Package for the per-interface Ethernet statistics block: register map,
  counter indices, field positions, reset values and frame-size limits.
  Assumes a 32-bit AXI4-Lite register bus with 8-bit byte addresses.
*/
package ess_pkg;
  localparam int unsigned NUM_IF   = 4;
  localparam int unsigned IF_W     = 2;
  localparam int unsigned CNT_W    = 32;
  localparam int unsigned LEN_W    = 16;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned NUM_CNT  = 22;

  // Register byte offsets
  localparam logic [7:0] OFS_SEL    = 8'h00;
  localparam logic [7:0] OFS_CTRL   = 8'h04;
  localparam logic [7:0] OFS_TEST   = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_QLEN   = 8'h10;
  localparam logic [7:0] OFS_MTU    = 8'h14;
  localparam logic [7:0] OFS_CNT    = 8'h40;

  // Field positions
  localparam int unsigned CTRL_CLEAR_BIT  = 0;
  localparam int unsigned STAT_LINK_BIT   = 0;
  localparam int unsigned STAT_FULL_BIT   = 1;
  localparam int unsigned STAT_TEST_BIT   = 2;

  // Reset values and fixed reported values
  localparam logic [IF_W-1:0]   SEL_RESET   = 2'h0;
  localparam logic [NUM_IF-1:0] TEST_RESET  = 4'h0;
  localparam logic [31:0]       TX_QUEUE_FRAMES = 32'h0000_0040;
  localparam logic [31:0]       MTU_BYTES       = 32'h0000_05EA;

  // Frame-size limits, check bytes included
  localparam logic [LEN_W-1:0] LEN_MIN   = 16'h0040;
  localparam logic [LEN_W-1:0] LEN_MAX   = 16'h05EE;
  localparam logic [LEN_W-1:0] LEN_B127  = 16'h007F;
  localparam logic [LEN_W-1:0] LEN_B255  = 16'h00FF;
  localparam logic [LEN_W-1:0] LEN_B511  = 16'h01FF;
  localparam logic [LEN_W-1:0] LEN_B1023 = 16'h03FF;

  // Counter indices; counter k sits at OFS_CNT + 4*k
  localparam int unsigned C_TX_BYTES   = 0;
  localparam int unsigned C_TX_SINGLE  = 1;
  localparam int unsigned C_TX_GROUP   = 2;
  localparam int unsigned C_TX_CLEAN   = 3;
  localparam int unsigned C_TX_ERROR   = 4;
  localparam int unsigned C_DROP_EVT   = 5;
  localparam int unsigned C_COLLIDE    = 6;
  localparam int unsigned C_BCAST      = 7;
  localparam int unsigned C_MCAST      = 8;
  localparam int unsigned C_CRC_ALIGN  = 9;
  localparam int unsigned C_UNDERSIZE  = 10;
  localparam int unsigned C_OVERSIZE   = 11;
  localparam int unsigned C_FRAGMENT   = 12;
  localparam int unsigned C_JABBER     = 13;
  localparam int unsigned C_RX_FRAMES  = 14;
  localparam int unsigned C_RX_BYTES   = 15;
  localparam int unsigned C_HIST_64    = 16;
  localparam int unsigned C_HIST_127   = 17;
  localparam int unsigned C_HIST_255   = 18;
  localparam int unsigned C_HIST_511   = 19;
  localparam int unsigned C_HIST_1023  = 20;
  localparam int unsigned C_HIST_1518  = 21;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ess_pkg

/* File: rtl/ess_stats.sv */
/*
  Per-interface Ethernet statistics: transmit interface counters, remote
  monitoring receive counters, length histogram, link/duplex/test status,
  all reached over an AXI4-Lite slave.
  Assumes frame events come from MAC logic on CLOCK_I as one-cycle pulses,
  while link and duplex levels come from pins and are synchronised here.
*/
// How it works
// - Sum transmitted bytes per interface
// - Count single and group destination transmits apart
// - Count clean transmit frames dropped
// - Count errored transmit drops in one counter
// - Testing interface passes no frames
// - Report link present or absent
// - Report half or full duplex
// - Clear command zeroes selected interface counters
// - Drop events counted per occasion
// - Count collisions per interface
// - Count good broadcast frames, not multicast
// - Count good multicast frames, not broadcast
// - Count check-sequence or alignment failures
// - Short frames with good check: undersized
// - Long frames with good check: oversized
// - Short frames with bad check: fragments
// - Long frames with bad check: jabbers
// - Count every received frame except on an interface under test
// - Sum every received byte except on an interface under test
// - Bin received frames by length
// - Report transmit queue depth in frames
// - Report largest frame size
`timescale 1ns/1ps
module ess_stats
  import ess_pkg::*;
(
  input  wire logic                         CLOCK_I,
  input  wire logic                         RST_N_I,
  input  wire logic                         CE_I,
  // Transmit frame events
  input  wire logic                         TX_DONE_I,
  input  wire logic                         TX_CLEAN_DROP_I,
  input  wire logic                         TX_ERR_DROP_I,
  input  wire logic [ess_pkg::IF_W-1:0]     TX_IF_I,
  input  wire logic [ess_pkg::LEN_W-1:0]    TX_LEN_I,
  input  wire logic                         TX_GROUP_I,
  // Receive frame events
  input  wire logic                         RX_DONE_I,
  input  wire logic [ess_pkg::IF_W-1:0]     RX_IF_I,
  input  wire logic [ess_pkg::LEN_W-1:0]    RX_LEN_I,
  input  wire logic                         RX_FCS_BAD_I,
  input  wire logic                         RX_ALIGN_ERR_I,
  input  wire logic                         RX_BCAST_I,
  input  wire logic                         RX_MCAST_I,
  input  wire logic [ess_pkg::NUM_IF-1:0]   DROP_EVT_I,
  input  wire logic [ess_pkg::NUM_IF-1:0]   COLLISION_I,
  // Pin levels; link and duplex inputs asynchronous
  input  wire logic [ess_pkg::NUM_IF-1:0]   LINK_UP_I,
  input  wire logic [ess_pkg::NUM_IF-1:0]   FULL_DUPLEX_I,
  output logic      [ess_pkg::NUM_IF-1:0]   PASS_EN_O,
  // AXI4-Lite slave
  input  wire logic [ess_pkg::ADDR_W-1:0]   S_AXI_AWADDR,
  input  wire logic                         S_AXI_AWVALID,
  output logic                              S_AXI_AWREADY,
  input  wire logic [31:0]                  S_AXI_WDATA,
  input  wire logic [3:0]                   S_AXI_WSTRB,
  input  wire logic                         S_AXI_WVALID,
  output logic                              S_AXI_WREADY,
  output logic [1:0]                        S_AXI_BRESP,
  output logic                              S_AXI_BVALID,
  input  wire logic                         S_AXI_BREADY,
  input  wire logic [ess_pkg::ADDR_W-1:0]   S_AXI_ARADDR,
  input  wire logic                         S_AXI_ARVALID,
  output logic                              S_AXI_ARREADY,
  output logic [31:0]                       S_AXI_RDATA,
  output logic [1:0]                        S_AXI_RRESP,
  output logic                              S_AXI_RVALID,
  input  wire logic                         S_AXI_RREADY
);
  typedef struct packed {
    logic [NUM_IF-1:0][NUM_CNT-1:0][CNT_W-1:0] cnt;
    logic [IF_W-1:0]   sel;
    logic [NUM_IF-1:0] test;
    logic [NUM_IF-1:0] link_s1;
    logic [NUM_IF-1:0] link_s2;
    logic [NUM_IF-1:0] dup_s1;
    logic [NUM_IF-1:0] dup_s2;
    logic              aw_got;
    logic              w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } ess_state_t;

  ess_state_t state_reg;
  ess_state_t state_next;

  // Address decode shared by the read and write paths
  function automatic logic ess_addr_ok(input logic [ADDR_W-1:0] a, input logic wr);
    logic ok;
    ok = 1'b0;
    if (a[1:0] == 2'h0)
    begin
      if (a == OFS_SEL || a == OFS_CTRL || a == OFS_TEST)
        ok = 1'b1;
      else if (!wr && (a == OFS_STATUS || a == OFS_QLEN || a == OFS_MTU))
        ok = 1'b1;
      else if (!wr && a >= OFS_CNT && a < OFS_CNT + ADDR_W'(4 * NUM_CNT))
        ok = 1'b1;
    end
    return ok;
  endfunction : ess_addr_ok

  // Histogram bin index for a length, or NUM_CNT when outside every bin
  function automatic int unsigned ess_bin(input logic [LEN_W-1:0] len);
    int unsigned b;
    b = NUM_CNT;
    if (len == LEN_MIN)
      b = C_HIST_64;
    else if (len > LEN_MIN && len <= LEN_B127)
      b = C_HIST_127;
    else if (len > LEN_B127 && len <= LEN_B255)
      b = C_HIST_255;
    else if (len > LEN_B255 && len <= LEN_B511)
      b = C_HIST_511;
    else if (len > LEN_B511 && len <= LEN_B1023)
      b = C_HIST_1023;
    else if (len > LEN_B1023 && len <= LEN_MAX)
      b = C_HIST_1518;
    return b;
  endfunction : ess_bin

  logic                         wr_fire;
  logic                         wr_ok;
  logic                         do_clear;
  logic                         tx_live;
  logic                         rx_live;
  logic                         rx_bad;
  logic                         rx_good;
  logic [NUM_CNT-1:0][CNT_W-1:0] tx_add;
  logic [NUM_CNT-1:0][CNT_W-1:0] rx_add;
  logic [31:0]                  rd_word;
  logic [4:0]                   rd_idx;

  assign wr_fire  = state_reg.aw_got && state_reg.w_got;
  assign wr_ok    = ess_addr_ok(state_reg.awaddr, 1'b1);
  assign do_clear = wr_fire && wr_ok && state_reg.awaddr == OFS_CTRL
                    && state_reg.wstrb[0] && state_reg.wdata[CTRL_CLEAR_BIT];
  // Frame and drop events on an interface under test are not passed and not counted; collisions are still counted
  assign tx_live  = !state_reg.test[TX_IF_I];
  assign rx_live  = RX_DONE_I && !state_reg.test[RX_IF_I];
  assign rx_bad   = RX_FCS_BAD_I || RX_ALIGN_ERR_I;
  assign rx_good  = !rx_bad && RX_LEN_I >= LEN_MIN && RX_LEN_I <= LEN_MAX;
  assign rd_idx   = 5'((S_AXI_ARADDR - OFS_CNT) >> 2);

  always_comb
  begin
    tx_add = '0;
    if (tx_live)
    begin
      if (TX_DONE_I)
      begin
        tx_add[C_TX_BYTES]  = CNT_W'(TX_LEN_I);
        tx_add[C_TX_SINGLE] = CNT_W'(!TX_GROUP_I);
        tx_add[C_TX_GROUP]  = CNT_W'(TX_GROUP_I);
      end
      tx_add[C_TX_CLEAN] = CNT_W'(TX_CLEAN_DROP_I);
      tx_add[C_TX_ERROR] = CNT_W'(TX_ERR_DROP_I);
    end
  end

  always_comb
  begin
    int unsigned bin;
    bin    = ess_bin(RX_LEN_I);
    rx_add = '0;
    if (rx_live)
    begin
      rx_add[C_BCAST]     = CNT_W'(rx_good && RX_BCAST_I);
      rx_add[C_MCAST]     = CNT_W'(rx_good && RX_MCAST_I && !RX_BCAST_I);
      rx_add[C_CRC_ALIGN] = CNT_W'(rx_bad);
      rx_add[C_UNDERSIZE] = CNT_W'(!RX_FCS_BAD_I && RX_LEN_I < LEN_MIN);
      rx_add[C_OVERSIZE]  = CNT_W'(!RX_FCS_BAD_I && RX_LEN_I > LEN_MAX);
      rx_add[C_FRAGMENT]  = CNT_W'(RX_FCS_BAD_I && RX_LEN_I < LEN_MIN);
      rx_add[C_JABBER]    = CNT_W'(RX_FCS_BAD_I && RX_LEN_I > LEN_MAX);
      rx_add[C_RX_FRAMES] = CNT_W'(1);
      rx_add[C_RX_BYTES]  = CNT_W'(RX_LEN_I);
      if (bin < NUM_CNT)
        rx_add[bin] = CNT_W'(1);
    end
  end

  always_comb
  begin
    rd_word = '0;
    if (S_AXI_ARADDR == OFS_SEL)
      rd_word = 32'(state_reg.sel);
    else if (S_AXI_ARADDR == OFS_TEST)
      rd_word = 32'(state_reg.test);
    else if (S_AXI_ARADDR == OFS_STATUS)
    begin
      rd_word[STAT_LINK_BIT] = state_reg.link_s2[state_reg.sel];
      rd_word[STAT_FULL_BIT] = state_reg.dup_s2[state_reg.sel];
      rd_word[STAT_TEST_BIT] = state_reg.test[state_reg.sel];
    end
    else if (S_AXI_ARADDR == OFS_QLEN)
      rd_word = TX_QUEUE_FRAMES;
    else if (S_AXI_ARADDR == OFS_MTU)
      rd_word = MTU_BYTES;
    else if (ess_addr_ok(S_AXI_ARADDR, 1'b0) && S_AXI_ARADDR >= OFS_CNT)
      rd_word = state_reg.cnt[state_reg.sel][rd_idx];
  end

  always_comb
  begin
    state_next         = state_reg;
    state_next.link_s1 = LINK_UP_I;
    state_next.link_s2 = state_reg.link_s1;
    state_next.dup_s1  = FULL_DUPLEX_I;
    state_next.dup_s2  = state_reg.dup_s1;

    for (int i = 0; i < NUM_IF; i++)
    begin
      for (int k = 0; k < NUM_CNT; k++)
      begin
        logic [CNT_W-1:0] sum;
        sum = state_reg.cnt[i][k];
        if (TX_IF_I == IF_W'(i))
          sum = sum + tx_add[k];
        if (RX_IF_I == IF_W'(i))
          sum = sum + rx_add[k];
        if (k == C_DROP_EVT && !state_reg.test[i])
          sum = sum + CNT_W'(DROP_EVT_I[i]);
        if (k == C_COLLIDE)
          sum = sum + CNT_W'(COLLISION_I[i]);
        if (do_clear && state_reg.sel == IF_W'(i))
          sum = '0;
        state_next.cnt[i][k] = sum;
      end
    end

    // Write channel: address and data taken in either order
    if (S_AXI_AWVALID && S_AXI_AWREADY)
    begin
      state_next.aw_got = 1'b1;
      state_next.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY)
    begin
      state_next.w_got = 1'b1;
      state_next.wdata = S_AXI_WDATA;
      state_next.wstrb = S_AXI_WSTRB;
    end
    if (wr_fire)
    begin
      state_next.aw_got = 1'b0;
      state_next.w_got  = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp  = wr_ok ? RESP_OKAY : RESP_SLVERR;
      if (wr_ok && state_reg.wstrb[0] && state_reg.awaddr == OFS_SEL)
        state_next.sel = state_reg.wdata[IF_W-1:0];
      if (wr_ok && state_reg.wstrb[0] && state_reg.awaddr == OFS_TEST)
        state_next.test = state_reg.wdata[NUM_IF-1:0];
    end
    if (state_reg.bvalid && S_AXI_BREADY)
      state_next.bvalid = 1'b0;

    if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      state_next.rvalid = 1'b1;
      state_next.rdata  = rd_word;
      state_next.rresp  = ess_addr_ok(S_AXI_ARADDR, 1'b0) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (state_reg.rvalid && S_AXI_RREADY)
      state_next.rvalid = 1'b0;
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      state_reg      <= '0;
      state_reg.sel  <= SEL_RESET;
      state_reg.test <= TEST_RESET;
    end
    else if (CE_I)
      state_reg <= state_next;
  end

  // Handshakes are masked while CE_I is low: the frozen state cannot take or
  // retire a beat, so the master must not see one complete
  assign S_AXI_AWREADY = CE_I && !state_reg.aw_got && !state_reg.bvalid;
  assign S_AXI_WREADY  = CE_I && !state_reg.w_got && !state_reg.bvalid;
  assign S_AXI_BVALID  = CE_I && state_reg.bvalid;
  assign S_AXI_BRESP   = state_reg.bresp;
  assign S_AXI_ARREADY = CE_I && !state_reg.rvalid;
  assign S_AXI_RVALID  = CE_I && state_reg.rvalid;
  assign S_AXI_RDATA   = state_reg.rdata;
  assign S_AXI_RRESP   = state_reg.rresp;
  assign PASS_EN_O     = ~state_reg.test;

  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);

  sequence s_tx_frame;
    CE_I && TX_DONE_I && !state_reg.test[TX_IF_I]
      && !(do_clear && state_reg.sel == TX_IF_I);
  endsequence

  sequence s_rx_frame;
    CE_I && rx_live && !(do_clear && state_reg.sel == RX_IF_I);
  endsequence

  property p_tx_bytes;
    s_tx_frame |=> state_reg.cnt[$past(TX_IF_I)][C_TX_BYTES]
      == $past(state_reg.cnt[TX_IF_I][C_TX_BYTES]) + CNT_W'($past(TX_LEN_I));
  endproperty
  a_tx_bytes: assert property (p_tx_bytes) else $error("tx byte sum wrong");

  property p_tx_single;
    s_tx_frame ##0 !TX_GROUP_I |=> state_reg.cnt[$past(TX_IF_I)][C_TX_SINGLE]
      == $past(state_reg.cnt[TX_IF_I][C_TX_SINGLE]) + CNT_W'(1);
  endproperty
  a_tx_single: assert property (p_tx_single) else $error("unicast count wrong");

  property p_test_block;
    CE_I && TX_DONE_I && state_reg.test[TX_IF_I] && !wr_fire
      |=> state_reg.cnt[$past(TX_IF_I)][C_TX_BYTES]
        == $past(state_reg.cnt[TX_IF_I][C_TX_BYTES])
        && !PASS_EN_O[$past(TX_IF_I)];
  endproperty
  a_test_block: assert property (p_test_block) else $error("frame passed in test");

  property p_clear;
    CE_I && do_clear |=> state_reg.cnt[state_reg.sel][C_RX_FRAMES] == '0
      && state_reg.cnt[state_reg.sel][C_TX_BYTES] == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("clear left counter nonzero");

  property p_drop_once;
    CE_I && DROP_EVT_I[0] && !state_reg.test[0] && !(do_clear && state_reg.sel == 2'h0)
      |=> state_reg.cnt[0][C_DROP_EVT] == $past(state_reg.cnt[0][C_DROP_EVT]) + CNT_W'(1);
  endproperty
  a_drop_once: assert property (p_drop_once) else $error("drop event count wrong");

  property p_undersize;
    s_rx_frame ##0 (!RX_FCS_BAD_I && RX_LEN_I < LEN_MIN)
      |=> state_reg.cnt[$past(RX_IF_I)][C_UNDERSIZE]
        == $past(state_reg.cnt[RX_IF_I][C_UNDERSIZE]) + CNT_W'(1);
  endproperty
  a_undersize: assert property (p_undersize) else $error("undersize count wrong");

  property p_total;
    s_rx_frame |=> state_reg.cnt[$past(RX_IF_I)][C_RX_FRAMES]
      == $past(state_reg.cnt[RX_IF_I][C_RX_FRAMES]) + CNT_W'(1);
  endproperty
  a_total: assert property (p_total) else $error("total frame count wrong");

  property p_bin64;
    s_rx_frame ##0 (RX_LEN_I == LEN_MIN) |=> state_reg.cnt[$past(RX_IF_I)][C_HIST_64]
      == $past(state_reg.cnt[RX_IF_I][C_HIST_64]) + CNT_W'(1);
  endproperty
  a_bin64: assert property (p_bin64) else $error("64-byte bin wrong");
endmodule : ess_stats

/* File: tb/ess_mac_model.sv */
/*
  MAC-side model for the statistics block: transmit, receive, drop and
  collision event pulses plus link and duplex pin levels.
  Assumes the bench calls its tasks; one clock, the model has no reset.
*/
`timescale 1ns/1ps
module ess_mac_model
  import ess_pkg::*;
(
  input  wire logic                       clk_i,
  input  wire logic [ess_pkg::NUM_IF-1:0] pass_en_i,
  output logic                            tx_done_o,
  output logic                            tx_clean_o,
  output logic                            tx_err_o,
  output logic [ess_pkg::IF_W-1:0]        tx_if_o,
  output logic [ess_pkg::LEN_W-1:0]       tx_len_o,
  output logic                            tx_group_o,
  output logic                            rx_done_o,
  output logic [ess_pkg::IF_W-1:0]        rx_if_o,
  output logic [ess_pkg::LEN_W-1:0]       rx_len_o,
  output logic [3:0]                      rx_flags_o,
  output logic [ess_pkg::NUM_IF-1:0]      drop_o,
  output logic [ess_pkg::NUM_IF-1:0]      coll_o,
  output logic [ess_pkg::NUM_IF-1:0]      link_o,
  output logic [ess_pkg::NUM_IF-1:0]      fdx_o
);
  // Only a scenario probing the block's own gating sets this
  logic rogue = 1'b0;

  initial
  begin
    {tx_done_o, tx_clean_o, tx_err_o, rx_done_o, tx_group_o} = 5'h00;
    {tx_if_o, rx_if_o, tx_len_o, rx_len_o, rx_flags_o} = 40'h0;
    {drop_o, coll_o, link_o, fdx_o} = 16'h0000;
  end

  // Qualifiers show the inverse of the last value between frames
  task automatic send_tx(input logic [IF_W-1:0] i, input logic [LEN_W-1:0] n,
                         input logic g, input logic [2:0] k);
    if (!rogue && !pass_en_i[i])
      return;
    @(posedge clk_i);
    {tx_if_o, tx_len_o, tx_group_o} <= {i, n, g};
    {tx_done_o, tx_clean_o, tx_err_o} <= k;
    @(posedge clk_i);
    {tx_done_o, tx_clean_o, tx_err_o} <= 3'h0;
    {tx_if_o, tx_len_o, tx_group_o} <= ~{i, n, g};
  endtask : send_tx

  task automatic send_rx(input logic [IF_W-1:0] i, input logic [LEN_W-1:0] n,
                         input logic [3:0] f);
    if (!rogue && !pass_en_i[i])
      return;
    @(posedge clk_i);
    {rx_if_o, rx_len_o, rx_flags_o, rx_done_o} <= {i, n, f, 1'b1};
    @(posedge clk_i);
    {rx_if_o, rx_len_o, rx_flags_o, rx_done_o} <= {~{i, n, f}, 1'b0};
  endtask : send_rx

  task automatic ev(input logic [NUM_IF-1:0] d, input logic [NUM_IF-1:0] c);
    @(posedge clk_i);
    {drop_o, coll_o} <= {d, c};
    @(posedge clk_i);
    {drop_o, coll_o} <= 8'h00;
  endtask : ev

  task automatic set_pins(input logic [NUM_IF-1:0] l, input logic [NUM_IF-1:0] f);
    @(posedge clk_i);
    {link_o, fdx_o} <= {l, f};
  endtask : set_pins
endmodule : ess_mac_model

/* File: tb/ess_stats_tb.sv */
/*
  Self-checking bench for the statistics block: AXI4-Lite register tasks
  and frame-event scenarios through the MAC model.
  Assumes the package register map and the note's bus latencies.
*/
`timescale 1ns/1ps
module ess_stats_tb;
  import ess_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ce = 1'b1;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  wire logic   awready, wready, bvalid, arready, rvalid;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic        tx_done, tx_clean, tx_err, tx_group, rx_done;
  wire logic [1:0]  tx_if, rx_if;
  wire logic [15:0] tx_len, rx_len;
  wire logic [3:0]  rx_flags, drop, coll, link, fdx, pass_en;
  int num_errors = 0;
  int num_checks = 0;
  logic [31:0] ex [NUM_CNT];
  // Length and flags {fcs, align, bcast, mcast} at both edges of every bin
  logic [19:0] rxt [15] = '{{16'h0040, 4'h2}, {16'h0041, 4'h1}, {16'h007F, 4'h0},
    {16'h0080, 4'h9}, {16'h00FF, 4'h0}, {16'h0100, 4'h0}, {16'h01FF, 4'h4},
    {16'h0200, 4'h0}, {16'h03FF, 4'h0}, {16'h0400, 4'h3}, {16'h05EE, 4'h1},
    {16'h003F, 4'h0}, {16'h003F, 4'h8}, {16'h05EF, 4'h0}, {16'h05EF, 4'h8}};

  always #20 clk = ~clk;

  ess_mac_model mac (
    .clk_i(clk), .pass_en_i(pass_en), .tx_done_o(tx_done), .tx_clean_o(tx_clean),
    .tx_err_o(tx_err), .tx_if_o(tx_if), .tx_len_o(tx_len), .tx_group_o(tx_group),
    .rx_done_o(rx_done), .rx_if_o(rx_if), .rx_len_o(rx_len), .rx_flags_o(rx_flags),
    .drop_o(drop), .coll_o(coll), .link_o(link), .fdx_o(fdx)
  );

  ess_stats dut (
    .CLOCK_I(clk), .RST_N_I(rst_n), .CE_I(ce),
    .TX_DONE_I(tx_done), .TX_CLEAN_DROP_I(tx_clean), .TX_ERR_DROP_I(tx_err),
    .TX_IF_I(tx_if), .TX_LEN_I(tx_len), .TX_GROUP_I(tx_group),
    .RX_DONE_I(rx_done), .RX_IF_I(rx_if), .RX_LEN_I(rx_len),
    .RX_FCS_BAD_I(rx_flags[3]), .RX_ALIGN_ERR_I(rx_flags[2]),
    .RX_BCAST_I(rx_flags[1]), .RX_MCAST_I(rx_flags[0]),
    .DROP_EVT_I(drop), .COLLISION_I(coll), .LINK_UP_I(link), .FULL_DUPLEX_I(fdx),
    .PASS_EN_O(pass_en),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge clk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
    while (!done)
    begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        r = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge clk);
    {araddr, arvalid, rready} <= {a, 2'h3};
    while (!done)
    begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        {d, r} = {rdata, rresp};
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d, e);
  endtask : rc

  task automatic cc(input int unsigned k, input logic [31:0] e);
    rc(OFS_CNT + 8'(4 * k), e);
  endtask : cc

  task automatic test_end(input string s);
    $display("Test %s finished", s);
  endtask : test_end

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done

  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    $display("Error at %0t: watchdog expired", $time);
    test_done();
  end

  initial
  begin
    logic [15:0] len;
    logic [3:0]  f;
    logic [1:0]  r;
    logic [31:0] d;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk(32'(pass_en), 32'hF);
    rc(OFS_SEL, 32'h0);
    rc(OFS_TEST, 32'h0);
    rc(OFS_QLEN, TX_QUEUE_FRAMES);
    rc(OFS_MTU, MTU_BYTES);
    test_end("reset");
    mac.set_pins(4'h1, 4'h0);
    repeat (4) @(posedge clk);
    rc(OFS_STATUS, 32'h1);
    mac.set_pins(4'h0, 4'h1);
    repeat (4) @(posedge clk);
    rc(OFS_STATUS, 32'h2);
    test_end("status");
    mac.send_tx(2'h1, 16'h0064, 1'b0, 3'h4);
    mac.send_tx(2'h1, 16'h003C, 1'b1, 3'h4);
    mac.send_tx(2'h1, 16'h0064, 1'b0, 3'h2);
    mac.send_tx(2'h1, 16'h0064, 1'b0, 3'h1);
    mac.send_tx(2'h0, 16'h0064, 1'b0, 3'h1);
    wr(OFS_SEL, 32'h1, r);
    cc(C_TX_BYTES, 32'hA0);
    cc(C_TX_SINGLE, 32'h1);
    cc(C_TX_GROUP, 32'h1);
    cc(C_TX_CLEAN, 32'h1);
    cc(C_TX_ERROR, 32'h1);
    wr(OFS_SEL, 32'h0, r);
    cc(C_TX_BYTES, 32'h0);
    cc(C_TX_ERROR, 32'h1);
    test_end("transmit");
    foreach (ex[k]) ex[k] = 32'h0;
    for (int i = 0; i < 15; i++)
    begin
      {len, f} = rxt[i];
      mac.send_rx(2'h2, len, f);
      ex[C_RX_FRAMES]++;
      ex[C_RX_BYTES] += 32'(len);
      if (f[3] || f[2]) ex[C_CRC_ALIGN]++;
      if (len < 16'h0040) ex[f[3] ? C_FRAGMENT : C_UNDERSIZE]++;
      else if (len > 16'h05EE) ex[f[3] ? C_JABBER : C_OVERSIZE]++;
      else
      begin
        ex[len == 16'h0040 ? C_HIST_64 : len <= 16'h007F ? C_HIST_127 :
           len <= 16'h00FF ? C_HIST_255 : len <= 16'h01FF ? C_HIST_511 :
           len <= 16'h03FF ? C_HIST_1023 : C_HIST_1518]++;
        if (f[3:2] == 2'h0 && f[1]) ex[C_BCAST]++;
        if (f[3:2] == 2'h0 && f[0] && !f[1]) ex[C_MCAST]++;
      end
    end
    mac.ev(4'h4, 4'h4);
    mac.ev(4'h4, 4'h4);
    mac.ev(4'h1, 4'h4);
    {ex[C_DROP_EVT], ex[C_COLLIDE]} = {32'h2, 32'h3};
    wr(OFS_SEL, 32'h2, r);
    foreach (ex[k]) cc(k, ex[k]);
    test_end("receive");
    wr(OFS_CTRL, 32'h1, r);
    rc(OFS_CTRL, 32'h0);
    foreach (ex[k]) cc(k, 32'h0);
    wr(OFS_SEL, 32'h1, r);
    cc(C_TX_BYTES, 32'hA0);
    test_end("clear");
    wr(OFS_TEST, 32'h8, r);
    wr(OFS_SEL, 32'h3, r);
    @(negedge clk);
    chk(32'(pass_en), 32'h7);
    rc(OFS_STATUS, 32'h4);
    mac.rogue = 1'b1;
    mac.send_rx(2'h3, 16'h0040, 4'h0);
    mac.send_tx(2'h3, 16'h0040, 1'b0, 3'h4);
    mac.rogue = 1'b0;
    cc(C_RX_FRAMES, 32'h0);
    cc(C_TX_SINGLE, 32'h0);
    wr(OFS_TEST, 32'h0, r);
    mac.send_rx(2'h3, 16'h0040, 4'h0);
    cc(C_RX_FRAMES, 32'h1);
    // A frame pulsed while the clock enable is low must leave no trace
    ce <= 1'b0;
    mac.send_rx(2'h3, 16'h0040, 4'h0);
    ce <= 1'b1;
    cc(C_RX_FRAMES, 32'h1);
    // Frame lands on the very edge that applies the clear
    fork
      wr(OFS_CTRL, 32'h1, r);
      begin
        @(posedge clk);
        mac.send_rx(2'h3, 16'h0040, 4'h0);
      end
    join
    cc(C_RX_FRAMES, 32'h0);
    test_end("testing");
    rd(8'h30, d, r);
    chk(32'(r), 32'(RESP_SLVERR));
    chk(d, 32'h0);
    rd(8'h02, d, r);
    chk(32'(r), 32'(RESP_SLVERR));
    wr(OFS_QLEN, 32'h1, r);
    chk(32'(r), 32'(RESP_SLVERR));
    rc(OFS_QLEN, TX_QUEUE_FRAMES);
    test_end("bus errors");
    test_done();
  end
endmodule : ess_stats_tb
